/* rtl/olr_params.svh */
// constants of the reverse-output limit and ADC result register slice
`ifndef OLR_PARAMS_SVH
`define OLR_PARAMS_SVH

`define OLR_OFS_VOUT_LOW 8'h06
`define OLR_OFS_ILIM_LO 8'h08
`define OLR_OFS_ILIM_HI 8'h09
`define OLR_OFS_SYS_PWR 8'h26
`define OLR_OFS_IN_VOLT 8'h27
`define OLR_OFS_DCHG_CUR 8'h28
`define OLR_OFS_CHG_CUR 8'h29
`define OLR_OFS_CMP_VOLT 8'h2a
`define OLR_OFS_IN_CUR 8'h2b
`define OLR_RST_BYTE 8'h00
`define OLR_RST_WORD 16'h0000
`define OLR_VOUT_LSB_BIT 2
`define OLR_ILIM_RSVD_BIT 7
`define OLR_IBAT_RSVD_BIT 7
`define OLR_ILIM_STEP_MA 16'h0032
`define OLR_VBUS_STEP_MV 16'h0040
`define OLR_VBUS_BASE_MV 16'h0c80
`define OLR_IIN_STEP_MA 16'h0032
`define OLR_IIN_STEP_10M_MA 16'h0019
`define OLR_BITS_PER_BYTE 4'h8

`endif

/* rtl/olr_pkg.sv */
// types shared by the register slice
package olr_pkg;
   typedef logic [7:0] olr_byte_t;

   typedef enum logic [2:0] {
      OLR_ST_IDLE,
      OLR_ST_ADDR,
      OLR_ST_AACK,
      OLR_ST_WRITE,
      OLR_ST_WACK,
      OLR_ST_READ,
      OLR_ST_RACK
   } olr_state_e;

   typedef struct packed {
      olr_byte_t input_voltage;
      olr_byte_t system_power_reading;
      olr_byte_t charge_current_reading;
      olr_byte_t discharge_current_reading;
      olr_byte_t input_current_reading;
      olr_byte_t comparator_input_voltage;
   } olr_adc_s;
endpackage : olr_pkg

/* rtl/olr_adc_bank.sv */
// holding registers for the latest conversion results
`timescale 1ns/1ps
`default_nettype none
`include "olr_params.svh"
module olr_adc_bank
   import olr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // results from the converter
   input wire logic load,
   input wire olr_adc_s results,
   // held results
   output olr_adc_s held
);
   olr_adc_s held_q;
   olr_adc_s held_d;

   // only the converter strobe updates; the host has no path in here
   always_comb
   begin
      held_d = held_q;
      if (load)
      begin
         held_d = results;
         held_d.charge_current_reading[`OLR_IBAT_RSVD_BIT] = 1'b0;
         held_d.discharge_current_reading[`OLR_IBAT_RSVD_BIT] = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         held_q <= '0;
      else
         held_q <= held_d;
   end

   assign held = held_q;

   AST_IBAT_RSVD_ZERO: assert property (@(posedge clk) disable iff (rst)
      !held_q.charge_current_reading[7] && !held_q.discharge_current_reading[7])
      else $error("reserved current bit reads as one");
   AST_HOLD_NO_LOAD: assert property (@(posedge clk) disable iff (rst)
      !load |=> $stable(held_q))
      else $error("result changed without converter strobe");
endmodule : olr_adc_bank
`default_nettype wire

/* rtl/olr_regs.sv */
// two-wire register slice: reverse-output limits and ADC result bytes
`timescale 1ns/1ps
`default_nettype none
`include "olr_params.svh"
module olr_regs
   import olr_pkg::*;
#(
   // bus address of the device; value is arbitrary
   parameter logic [6:0] DEV_ADDR = 7'h2a
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // two-wire serial bus, open drain data
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // converter results
   input wire logic adc_load,
   input wire olr_adc_s adc_in,
   input wire logic sense_10mohm,
   // settings toward the power stage
   output logic [5:0] vout_low_code,
   output logic [6:0] ilim_code,
   output logic [15:0] ilim_ma,
   output logic [15:0] vbus_mv,
   output logic [15:0] iin_step_ma
);
   olr_state_e st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   olr_byte_t sh_q, sh_d;
   olr_byte_t ptr_q, ptr_d;
   logic first_q, first_d;
   logic rw_q, rw_d;
   logic nack_q, nack_d;
   logic scl_q, scl_d;
   logic sda_q, sda_d;
   logic sda_oe_q, sda_oe_d;
   logic sda_o_q, sda_o_d;
   olr_byte_t vout_q, vout_d;
   olr_byte_t ilim_lo_q, ilim_lo_d;
   olr_byte_t ilim_hi_q, ilim_hi_d;
   logic [15:0] ilim_ma_q, ilim_ma_d;
   logic [15:0] vbus_mv_q, vbus_mv_d;
   logic [15:0] iin_step_q, iin_step_d;
   logic rise, fall;
   logic wr_en;
   olr_byte_t wr_addr, wr_data;
   logic rd_load;
   olr_adc_s adc_q;

   olr_adc_bank u_adc (
      .clk(clk),
      .rst(rst),
      .load(adc_load),
      .results(adc_in),
      .held(adc_q)
   );

   function automatic logic [15:0] olr_scale(input olr_byte_t code, input logic [15:0] step,
                                             input logic [15:0] base);
      return 16'(base + 16'(code) * step);
   endfunction : olr_scale

   // read map; unmapped bytes read zero
   function automatic olr_byte_t olr_rd(input olr_byte_t a, input olr_adc_s r,
                                        input olr_byte_t v, input olr_byte_t lo,
                                        input olr_byte_t hi);
      case (a)
         `OLR_OFS_VOUT_LOW: return v;
         `OLR_OFS_ILIM_LO: return lo;
         `OLR_OFS_ILIM_HI: return hi;
         `OLR_OFS_SYS_PWR: return r.system_power_reading;
         `OLR_OFS_IN_VOLT: return r.input_voltage;
         `OLR_OFS_DCHG_CUR: return r.discharge_current_reading;
         `OLR_OFS_CHG_CUR: return r.charge_current_reading;
         `OLR_OFS_CMP_VOLT: return r.comparator_input_voltage;
         `OLR_OFS_IN_CUR: return r.input_current_reading;
         default: return `OLR_RST_BYTE;
      endcase
   endfunction : olr_rd

   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      first_d = first_q;
      rw_d = rw_q;
      nack_d = nack_q;
      sda_oe_d = sda_oe_q;
      sda_o_d = 1'b0;
      scl_d = scl_i;
      sda_d = sda_i;
      vout_d = vout_q;
      ilim_lo_d = ilim_lo_q;
      ilim_hi_d = ilim_hi_q;
      wr_en = 1'b0;
      wr_addr = ptr_q;
      wr_data = sh_q;
      rd_load = 1'b0;
      rise = scl_i & ~scl_q;
      fall = ~scl_i & scl_q;
      case (st_q)
         OLR_ST_IDLE:
         begin
         end
         OLR_ST_ADDR:
         begin
            if (rise)
            begin
               sh_d = {sh_q[6:0], sda_i};
               cnt_d = cnt_q + 4'h1;
            end
            else if (fall && cnt_q == `OLR_BITS_PER_BYTE)
            begin
               if (sh_q[7:1] == DEV_ADDR)
               begin
                  rw_d = sh_q[0];
                  sda_oe_d = 1'b1;
                  st_d = OLR_ST_AACK;
               end
               else
                  st_d = OLR_ST_IDLE;
            end
         end
         OLR_ST_AACK:
         begin
            if (fall)
            begin
               cnt_d = 4'h0;
               if (rw_q)
                  rd_load = 1'b1;
               else
               begin
                  sda_oe_d = 1'b0;
                  first_d = 1'b1;
                  st_d = OLR_ST_WRITE;
               end
            end
         end
         OLR_ST_WRITE:
         begin
            if (rise)
            begin
               sh_d = {sh_q[6:0], sda_i};
               cnt_d = cnt_q + 4'h1;
            end
            else if (fall && cnt_q == `OLR_BITS_PER_BYTE)
            begin
               if (first_q)
               begin
                  ptr_d = sh_q;
                  first_d = 1'b0;
               end
               else
               begin
                  wr_en = 1'b1;
                  ptr_d = ptr_q + 8'h01;
               end
               sda_oe_d = 1'b1;
               st_d = OLR_ST_WACK;
            end
         end
         OLR_ST_WACK:
         begin
            if (fall)
            begin
               sda_oe_d = 1'b0;
               cnt_d = 4'h0;
               st_d = OLR_ST_WRITE;
            end
         end
         OLR_ST_READ:
         begin
            if (rise)
               cnt_d = cnt_q + 4'h1;
            else if (fall)
            begin
               if (cnt_q == `OLR_BITS_PER_BYTE)
               begin
                  sda_oe_d = 1'b0;
                  st_d = OLR_ST_RACK;
               end
               else
               begin
                  sh_d = {sh_q[6:0], 1'b0};
                  sda_oe_d = ~sh_q[6];
               end
            end
         end
         OLR_ST_RACK:
         begin
            if (rise)
               nack_d = sda_i;
            else if (fall)
            begin
               if (!nack_q)
                  rd_load = 1'b1;
               else
                  st_d = OLR_ST_IDLE;
            end
         end
         default:
            st_d = OLR_ST_IDLE;
      endcase
      if (rd_load)
      begin
         sh_d = olr_rd(ptr_q, adc_q, vout_q, ilim_lo_q, ilim_hi_q);
         sda_oe_d = ~sh_d[7];
         ptr_d = ptr_q + 8'h01;
         cnt_d = 4'h0;
         st_d = OLR_ST_READ;
      end
      // only the three setting bytes take writes; result bytes drop them
      if (wr_en)
      begin
         case (wr_addr)
            `OLR_OFS_VOUT_LOW: vout_d = wr_data;
            `OLR_OFS_ILIM_LO: ilim_lo_d = wr_data;
            `OLR_OFS_ILIM_HI:
            begin
               if (!wr_data[`OLR_ILIM_RSVD_BIT])
                  ilim_hi_d = wr_data;
            end
            default:
            begin
            end
         endcase
      end
      // start and stop win over everything else
      if (scl_q && scl_i && sda_q && !sda_i)
      begin
         st_d = OLR_ST_ADDR;
         cnt_d = 4'h0;
         sda_oe_d = 1'b0;
      end
      else if (scl_q && scl_i && !sda_q && sda_i)
      begin
         st_d = OLR_ST_IDLE;
         sda_oe_d = 1'b0;
      end
      ilim_ma_d = olr_scale({1'b0, ilim_hi_q[6:0]}, `OLR_ILIM_STEP_MA, `OLR_RST_WORD);
      vbus_mv_d = olr_scale(adc_q.input_voltage, `OLR_VBUS_STEP_MV, `OLR_VBUS_BASE_MV);
      iin_step_d = sense_10mohm ? `OLR_IIN_STEP_10M_MA : `OLR_IIN_STEP_MA;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q <= OLR_ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= `OLR_RST_BYTE;
         ptr_q <= `OLR_RST_BYTE;
         first_q <= 1'b0;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         sda_oe_q <= 1'b0;
         sda_o_q <= 1'b0;
         vout_q <= `OLR_RST_BYTE;
         ilim_lo_q <= `OLR_RST_BYTE;
         ilim_hi_q <= `OLR_RST_BYTE;
         ilim_ma_q <= `OLR_RST_WORD;
         vbus_mv_q <= `OLR_VBUS_BASE_MV;
         iin_step_q <= `OLR_IIN_STEP_MA;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         first_q <= first_d;
         rw_q <= rw_d;
         nack_q <= nack_d;
         scl_q <= scl_d;
         sda_q <= sda_d;
         sda_oe_q <= sda_oe_d;
         sda_o_q <= sda_o_d;
         vout_q <= vout_d;
         ilim_lo_q <= ilim_lo_d;
         ilim_hi_q <= ilim_hi_d;
         ilim_ma_q <= ilim_ma_d;
         vbus_mv_q <= vbus_mv_d;
         iin_step_q <= iin_step_d;
      end
   end

   assign sda_o = sda_o_q;
   assign sda_oe = sda_oe_q;
   assign vout_low_code = vout_q[7:`OLR_VOUT_LSB_BIT];
   assign ilim_code = ilim_hi_q[6:0];
   assign ilim_ma = ilim_ma_q;
   assign vbus_mv = vbus_mv_q;
   assign iin_step_ma = iin_step_q;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_VOUT_LOAD: assert property (wr_en && wr_addr == 8'h06 |=> vout_low_code[0] == $past(wr_data[2]))
      else $error("voltage low bit not loaded");
   AST_ILIM_LOAD: assert property (wr_en && wr_addr == 8'h09 && !wr_data[7] |=> ilim_code == $past(wr_data[6:0]))
      else $error("limit code not loaded");
   AST_ILIM_INVALID: assert property (wr_en && wr_addr == 8'h09 && wr_data[7] |=> $stable(ilim_hi_q))
      else $error("invalid limit write took effect");
   AST_ILIM_MA: assert property (wr_en && wr_addr == 8'h09 && !wr_data[7] |=> ##1 ilim_ma == 16'(50 * $past(wr_data[6:0], 2)))
      else $error("limit in mA wrong");
   AST_LO_IGNORED: assert property (wr_en && wr_addr == 8'h08 |=> $stable(ilim_code) && $stable(ilim_ma))
      else $error("low limit byte steered the limit");
   AST_VBUS_MV: assert property (##1 vbus_mv == 16'(3200 + 64 * $past(adc_q.input_voltage)))
      else $error("input voltage scaling wrong");
   AST_IIN_STEP: assert property (sense_10mohm |=> iin_step_ma == 16'd25)
      else $error("input current step not halved");
   AST_RD_VBUS: assert property (rd_load && ptr_q == 8'h27 |=> sh_q == $past(adc_q.input_voltage))
      else $error("27h read wrong");
   AST_RD_SYSTEM_POWER_READING: assert property (rd_load && ptr_q == 8'h26 |=> sh_q == $past(adc_q.system_power_reading))
      else $error("26h read wrong");
   AST_RD_IIN: assert property (rd_load && ptr_q == 8'h2b |=> sh_q == $past(adc_q.input_current_reading))
      else $error("2Bh read wrong");
   AST_RD_CMP: assert property (rd_load && ptr_q == 8'h2a |=> sh_q == $past(adc_q.comparator_input_voltage))
      else $error("2Ah read wrong");
   AST_RD_CHARGE_CURRENT_READING: assert property (rd_load && ptr_q == 8'h29 |=> sh_q[7] == 1'b0 && sh_q[6:0] == $past(adc_q.charge_current_reading[6:0]))
      else $error("29h read wrong");
   AST_RO_WRITE: assert property (wr_en && wr_addr >= 8'h26 && wr_addr <= 8'h2b |=> $stable(adc_q) || $past(adc_load))
      else $error("result byte changed by host write");

   COV_LIMIT_WRITE: cover property (wr_en && wr_addr == 8'h09);
   COV_READ_VBUS: cover property (rd_load && ptr_q == 8'h27);
   COV_READ_NACK: cover property (st_q == OLR_ST_RACK && nack_q && fall);
endmodule : olr_regs
`default_nettype wire

/* dv/olr_host_model.sv */
// two-wire bus master model facing the register slice
`timescale 1ns/1ps
`default_nettype none
module olr_host_model (
   // clock
   input wire logic clk,
   // two-wire bus
   output logic scl,
   output logic sda_wire,
   input wire logic sda_oe
);
   logic sda_drv = 1'b1;
   initial scl = 1'b1;
   // pull-up: the line is low when either party pulls it
   assign sda_wire = sda_drv & ~sda_oe;

   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask : hold

   task automatic start_cond();
      sda_drv = 1'b1;
      hold(2);
      scl = 1'b1;
      hold(4);
      sda_drv = 1'b0;
      hold(4);
      scl = 1'b0;
      hold(2);
   endtask : start_cond

   task automatic stop_cond();
      sda_drv = 1'b0;
      hold(2);
      scl = 1'b1;
      hold(4);
      sda_drv = 1'b1;
      hold(4);
   endtask : stop_cond

   // data changes only while the clock line is low
   task automatic xfer_bit(input logic b, output logic r);
      sda_drv = b;
      hold(4);
      scl = 1'b1;
      hold(4);
      r = sda_wire;
      scl = 1'b0;
   endtask : xfer_bit

   task automatic xfer_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
      output logic ack);
      for (int i = 7; i >= 0; i--)
         xfer_bit(tx[i], rx[i]);
      xfer_bit(ack_in, ack);
   endtask : xfer_byte
endmodule : olr_host_model
`default_nettype wire

/* dv/olr_tb.sv */
// self-checking bench for the register slice
`timescale 1ns/1ps
`default_nettype none
module tb import olr_pkg::*;;
   localparam logic [6:0] ADDR = 7'h2a;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic adc_load = 1'b0;
   olr_adc_s adc_in = '0;
   logic sense_10mohm = 1'b0;
   logic scl;
   logic sda;
   logic sda_oe;
   logic sda_o;
   olr_byte_t rx0;
   logic ack0;
   logic [5:0] vout_low_code;
   logic [6:0] ilim_code;
   logic [15:0] ilim_ma;
   logic [15:0] vbus_mv;
   logic [15:0] iin_step_ma;
   logic [31:0] seed = 32'hd7129bd4;
   olr_byte_t hi;
   olr_byte_t v;
   olr_byte_t q[$];
   olr_byte_t e[$];
   int fail_count = 0;
   int total_checks = 0;
   int cyc = 0;

   always #2 clk = ~clk;

   olr_host_model host_u (.clk(clk), .scl(scl), .sda_wire(sda), .sda_oe(sda_oe));
   olr_regs #(.DEV_ADDR(ADDR)) dut_u (.clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe(sda_oe), .adc_load(adc_load), .adc_in(adc_in),
      .sense_10mohm(sense_10mohm), .vout_low_code(vout_low_code), .ilim_code(ilim_code),
      .ilim_ma(ilim_ma), .vbus_mv(vbus_mv), .iin_step_ma(iin_step_ma));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      logic [31:0] r;
      r = s;
      repeat (32) r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
      return r;
   endfunction : lfsr

   // limit in mA from the binary weights, 50 mA for the lowest bit
   function automatic logic [15:0] exp_ilim_ma(input olr_byte_t code);
      return 16'(code[6:0]) * 16'h0032;
   endfunction : exp_ilim_ma

   // input voltage in mV: 3200 mV floor plus 64 mV per step
   function automatic logic [15:0] exp_vbus_mv(input olr_byte_t code);
      return 16'h0c80 + 16'(code) * 16'h0040;
   endfunction : exp_vbus_mv

   task automatic end_of_test();
      if (fail_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic cmp_all();
      foreach (e[i])
         chk(16'(q[i]), 16'(e[i]));
   endtask : cmp_all

   // pointer auto-increments per data byte
   task automatic wr(input olr_byte_t ptr, input olr_byte_t d[$]);
      olr_byte_t rx;
      logic a;
      host_u.start_cond();
      host_u.xfer_byte({ADDR, 1'b0}, 1'b1, rx, a);
      chk(16'(a), 16'h0000);
      host_u.xfer_byte(ptr, 1'b1, rx, a);
      foreach (d[i])
         host_u.xfer_byte(d[i], 1'b1, rx, a);
      host_u.stop_cond();
   endtask : wr

   // last byte is refused by the master to end the read
   task automatic rd(input olr_byte_t ptr, input int n);
      olr_byte_t rx;
      logic a;
      q = {};
      host_u.start_cond();
      host_u.xfer_byte({ADDR, 1'b0}, 1'b1, rx, a);
      host_u.xfer_byte(ptr, 1'b1, rx, a);
      host_u.start_cond();
      host_u.xfer_byte({ADDR, 1'b1}, 1'b1, rx, a);
      for (int i = 0; i < n; i++)
      begin
         host_u.xfer_byte(8'hff, i == n - 1, rx, a);
         q.push_back(rx);
      end
      host_u.stop_cond();
      chk(16'(sda_o), 16'h0000);
   endtask : rd

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         fail_count++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(16'(vout_low_code), 16'h0000);
      chk(16'(ilim_code), 16'h0000);
      chk(ilim_ma, 16'h0000);
      chk(vbus_mv, 16'h0c80);
      chk(iin_step_ma, 16'h0032);
      for (int i = 0; i < 3; i++)
      begin
         seed = lfsr(seed);
         v = (i == 0) ? 8'h04 : seed[7:0];
         wr(8'h06, {v});
         chk(16'(vout_low_code), 16'(v[7:2]));
         rd(8'h06, 1);
         chk(16'(q[0]), 16'(v));
      end
      for (int i = 0; i < 3; i++)
      begin
         seed = lfsr(seed);
         hi = (i == 0) ? 8'h7f : {1'b0, seed[14:8]};
         wr(8'h08, {seed[7:0], hi});
         chk(16'(ilim_code), 16'(hi));
         chk(ilim_ma, exp_ilim_ma(hi));
         rd(8'h08, 2);
         chk(16'(q[0]), 16'(seed[7:0]));
         chk(16'(q[1]), 16'(hi));
      end
      wr(8'h09, {8'h80 | seed[23:16]});
      chk(16'(ilim_code), 16'(hi));
      // a frame for another bus address must be ignored entirely
      host_u.start_cond();
      host_u.xfer_byte({ADDR ^ 7'h01, 1'b0}, 1'b1, rx0, ack0);
      chk(16'(ack0), 16'h0001);
      host_u.xfer_byte(8'h09, 1'b1, rx0, ack0);
      host_u.xfer_byte(~hi, 1'b1, rx0, ack0);
      host_u.stop_cond();
      chk(16'(ilim_code), 16'(hi));
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         adc_in = (i < 2) ? {48{i == 0}} : {seed, seed[15:0] ^ seed[31:16]};
         adc_load = 1'b1;
         @(negedge clk);
         adc_load = 1'b0;
         repeat (2) @(negedge clk);
         chk(vbus_mv, exp_vbus_mv(adc_in.input_voltage));
         e = {adc_in.system_power_reading, adc_in.input_voltage,
            adc_in.discharge_current_reading & 8'h7f, adc_in.charge_current_reading & 8'h7f,
            adc_in.comparator_input_voltage, adc_in.input_current_reading};
         rd(8'h26, 6);
         cmp_all();
         seed = lfsr(seed);
         wr(8'h26, {seed[7:0], seed[15:8], seed[23:16], seed[31:24], 8'hff, 8'h00});
         rd(8'h26, 6);
         cmp_all();
         chk(16'(ilim_code), 16'(hi));
         chk(16'(vout_low_code), 16'(v[7:2]));
      end
      // reset in mid-run must clear the written settings again
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(16'(vout_low_code), 16'h0000);
      chk(16'(ilim_code), 16'h0000);
      chk(ilim_ma, 16'h0000);
      chk(vbus_mv, exp_vbus_mv(8'h00));
      sense_10mohm = 1'b1;
      repeat (2) @(negedge clk);
      chk(iin_step_ma, 16'h0019);
      sense_10mohm = 1'b0;
      repeat (2) @(negedge clk);
      chk(iin_step_ma, 16'h0032);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
